// ---- aro_params.svh ----
// constants of the result output port
`ifndef ARO_PARAMS_SVH
`define ARO_PARAMS_SVH
`define ARO_NCH 8
`define ARO_WORD_W 32
`define ARO_FIFO_DEPTH 8
`define ARO_NLINES 4
`define ARO_LINE_BITS 256
`define ARO_LAST_CH 3'h7
`define ARO_WORD_LAST 5'h1F
`define ARO_BITS_W 9
`define ARO_DIV_W 7
`define ARO_FMT_RESET 2'h0
`define ARO_DRV_RESET 2'h0
`endif

// ---- aro_pkg.sv ----
// types of the result output port
package aro_pkg;
	typedef enum logic [1:0] {
		ARO_FMT_QUAD = 2'b00,
		ARO_FMT_DUAL = 2'b01,
		ARO_FMT_SINGLE = 2'b10,
		ARO_FMT_RSVD = 2'b11
	} aro_fmt_e;
	typedef enum logic [1:0] {
		ARO_DRV_NOMINAL = 2'b00,
		ARO_DRV_STRONG = 2'b01,
		ARO_DRV_WEAK = 2'b10,
		ARO_DRV_XSTRONG = 2'b11
	} aro_drive_e;
endpackage

// ---- aro_fifo.sv ----
// result word fifo with valid/ready on both sides
`timescale 1ns/100ps
module aro_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // aro_fifo

// ---- aro_port.sv ----
// conversion result output port: serial result lines and spi readback
`timescale 1ns/100ps
`include "aro_params.svh"
module aro_port #(
	parameter int NCH = `ARO_NCH,
	parameter int WORD_W = `ARO_WORD_W,
	parameter int FIFO_DEPTH = `ARO_FIFO_DEPTH
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// result words from the converter core
	input wire logic SAMPLE_VALID,
	input wire logic [WORD_W-1:0] SAMPLE_DATA,
	output logic SAMPLE_READY,
	input wire logic HOLD_RESULTS,
	// configuration
	input wire logic REG_CONTROL,
	input wire logic FORMAT_PIN_0,
	input wire logic FORMAT_PIN_1,
	input wire logic [1:0] FORMAT_FIELD,
	input wire logic [2:0] RESULT_BIT_CLOCK_SELECT,
	input wire logic [2:0] BIT_CLOCK_DIVIDER_CODE,
	input wire logic [1:0] DRIVE_FIELD,
	input wire logic DAISY_EN,
	input wire logic SPI_READ_EN,
	// serial result lines
	output logic RESULT_BIT_CLOCK,
	output logic [3:0] RESULT_LINES_O,
	output logic [3:0] RESULT_LINES_OE_N,
	input wire logic [3:0] RESULT_LINES_I,
	output logic [1:0] LINE_DRIVE_STRENGTH,
	// spi readback
	input wire logic SPI_SCLK,
	input wire logic SPI_CS_N,
	output logic SPI_SDO,
	output logic SPI_SDO_OE_N,
	// status
	output logic RESULT_READY_STROBE_N,
	output logic [2:0] READ_CHANNEL,
	output logic OVERRUN
);
	localparam int NL = `ARO_NLINES;
	localparam int LB = `ARO_LINE_BITS;

	logic pop;
	logic [WORD_W-1:0] fifo_data;
	logic fifo_valid;
	logic [WORD_W-1:0] stage_q [NCH];
	logic [WORD_W-1:0] frame_q [NCH];
	logic [2:0] idx_q;
	logic conv_q;
	logic cap_done_q;
	logic [1:0] pin_fmt_q;
	logic [1:0] fmt_raw;
	aro_pkg::aro_fmt_e fmt_q;
	aro_pkg::aro_fmt_e line_fmt_q;
	logic daisy_q;
	logic [`ARO_DIV_W-1:0] div_cnt_q;
	logic [`ARO_DIV_W-1:0] half_m1;
	logic bclk_q;
	logic bit_hit;
	logic bit_rise, bit_fall;
	logic [LB-1:0] sr_q [NL];
	logic [LB-1:0] load_vec [NL];
	logic [NL-1:0] chain_q;
	logic [NL-1:0] fill;
	logic [NL-1:0] oe_n_q;
	logic [NL-1:0] oe_n_d;
	logic [`ARO_BITS_W-1:0] bits_q;
	logic [`ARO_BITS_W-1:0] own_bits;
	logic [`ARO_BITS_W-1:0] own_bits_q;
	logic overrun_q;
	logic strobe_n_q;
	logic [1:0] drive_q;
	logic [2:0] rd_ch_q;
	logic sclk_q, cs_q;
	logic cs_act;
	logic sclk_rise, sclk_fall;
	logic [4:0] spi_bit_q;
	logic word_done_q;
	logic [WORD_W-1:0] spi_sr_q;

	// a held drain lets the fifo fill and stall the core
	assign pop = fifo_valid & ~HOLD_RESULTS;

	aro_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst_n(RST_N),
		.in_valid(SAMPLE_VALID),
		.in_data(SAMPLE_DATA),
		.in_ready(SAMPLE_READY),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(~HOLD_RESULTS)
	);

	// collect one conversion, one word per channel
	always_ff @(posedge MCLK) begin
		if (pop) begin
			stage_q[idx_q] <= fifo_data;
		end
		if (conv_q) begin
			frame_q <= stage_q;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			idx_q <= 3'h0;
			conv_q <= 1'b0;
		end else begin
			conv_q <= pop & (idx_q == 3'(NCH-1));
			if (pop) begin
				idx_q <= (idx_q == 3'(NCH-1)) ? 3'h0 : idx_q + 3'h1;
			end
		end
	end

	// format pins are strapped: caught once after reset release
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cap_done_q <= 1'b0;
			pin_fmt_q <= `ARO_FMT_RESET;
		end else if (!cap_done_q) begin
			cap_done_q <= 1'b1;
			pin_fmt_q <= {FORMAT_PIN_1, FORMAT_PIN_0};
		end
	end

	assign fmt_raw = REG_CONTROL ? FORMAT_FIELD : pin_fmt_q;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			fmt_q <= aro_pkg::ARO_FMT_QUAD;
		end else if (fmt_raw != aro_pkg::ARO_FMT_RSVD) begin
			fmt_q <= aro_pkg::aro_fmt_e'(fmt_raw);
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			drive_q <= `ARO_DRV_RESET;
		end else begin
			drive_q <= REG_CONTROL ? DRIVE_FIELD : 2'(aro_pkg::ARO_DRV_NOMINAL);
		end
	end
	assign LINE_DRIVE_STRENGTH = drive_q;

	assign half_m1 = `ARO_DIV_W'((8'h01 << (REG_CONTROL ? BIT_CLOCK_DIVIDER_CODE :
		RESULT_BIT_CLOCK_SELECT)) - 8'h01);
	assign bit_hit = (div_cnt_q == half_m1) | (div_cnt_q > half_m1);
	assign bit_rise = bit_hit & ~bclk_q;
	assign bit_fall = bit_hit & bclk_q;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			div_cnt_q <= '0;
			bclk_q <= 1'b0;
		end else if (conv_q) begin
			div_cnt_q <= '0;
			bclk_q <= 1'b0;
		end else if (bit_hit) begin
			div_cnt_q <= '0;
			bclk_q <= ~bclk_q;
		end else begin
			div_cnt_q <= div_cnt_q + `ARO_DIV_W'(1);
		end
	end
	assign RESULT_BIT_CLOCK = bclk_q;

	// channel to line mapping of the new conversion
	generate
		for (genvar l = 0; l < NL; l++) begin : g_line
			always_comb begin
				int cpl;
				int ch;
				ch = 0;
				cpl = (fmt_q == aro_pkg::ARO_FMT_QUAD) ? 2 :
					(fmt_q == aro_pkg::ARO_FMT_DUAL) ? 4 : 8;
				load_vec[l] = '0;
				for (int s = 0; s < NCH; s++) begin
					ch = l * cpl + s;
					if (s < cpl && ch < NCH) begin
						load_vec[l][LB-1-WORD_W*s -: WORD_W] = stage_q[ch];
					end
				end
			end

			// chain input sampled on rising edge
			always_ff @(posedge MCLK or negedge RST_N) begin
				if (!RST_N) begin
					chain_q[l] <= 1'b0;
				end else if (bit_rise) begin
					chain_q[l] <= RESULT_LINES_I[(l + 2) % NL];
				end
			end

			// zeros or chain follow own bits
			always_ff @(posedge MCLK or negedge RST_N) begin
				if (!RST_N) begin
					sr_q[l] <= '0;
				end else if (conv_q) begin
					sr_q[l] <= load_vec[l];
				end else if (bit_fall) begin
					sr_q[l] <= {sr_q[l][LB-2:0], 1'b0} | (LB'(fill[l]) << (LB - own_bits_q));
				end
			end
			assign RESULT_LINES_O[l] = sr_q[l][LB-1];
		end
	endgenerate

	// dual chain, lines 0 and 1 forward inputs 2 and 3
	// single chain, line 0 forwards input 2
	always_comb begin
		fill = '0;
		if (daisy_q) begin
			unique case (line_fmt_q)
				aro_pkg::ARO_FMT_DUAL: fill = {2'b00, chain_q[1], chain_q[0]};
				aro_pkg::ARO_FMT_SINGLE: fill = {3'b000, chain_q[0]};
				default: fill = '0;
			endcase
		end
	end

	// lines 2 and 3 released as inputs in chain modes, line 1 as well in single
	always_comb begin
		unique case (fmt_q)
			aro_pkg::ARO_FMT_DUAL: oe_n_d = 4'hC;
			aro_pkg::ARO_FMT_SINGLE: oe_n_d = 4'hE;
			default: oe_n_d = 4'h0;
		endcase
		unique case (fmt_q)
			aro_pkg::ARO_FMT_DUAL: own_bits = `ARO_BITS_W'(4 * WORD_W);
			aro_pkg::ARO_FMT_SINGLE: own_bits = `ARO_BITS_W'(8 * WORD_W);
			default: own_bits = `ARO_BITS_W'(2 * WORD_W);
		endcase
	end

	// line setup changes only between conversions
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			line_fmt_q <= aro_pkg::ARO_FMT_QUAD;
			oe_n_q <= 4'h0;
			daisy_q <= 1'b0;
			own_bits_q <= `ARO_BITS_W'(2 * WORD_W);
		end else if (conv_q) begin
			line_fmt_q <= fmt_q;
			oe_n_q <= oe_n_d;
			daisy_q <= DAISY_EN & (fmt_q != aro_pkg::ARO_FMT_QUAD);
			own_bits_q <= own_bits;
		end
	end
	assign RESULT_LINES_OE_N = oe_n_q;

	// a new conversion overwrites unsent bits
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			bits_q <= '0;
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= conv_q & (bits_q < own_bits_q) & (bits_q != '0);
			if (conv_q) begin
				bits_q <= '0;
			end else if (bit_fall & (bits_q < own_bits_q)) begin
				bits_q <= bits_q + `ARO_BITS_W'(1);
			end
		end
	end
	assign OVERRUN = overrun_q;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			strobe_n_q <= 1'b1;
		end else if (conv_q) begin
			strobe_n_q <= ~strobe_n_q;
		end
	end
	assign RESULT_READY_STROBE_N = strobe_n_q;

	// spi clock comes from the host
	assign cs_act = ~SPI_CS_N & SPI_READ_EN;
	assign sclk_rise = cs_act & SPI_SCLK & ~sclk_q;
	assign sclk_fall = cs_act & ~SPI_SCLK & sclk_q;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b0;
		end else begin
			sclk_q <= SPI_SCLK;
			cs_q <= cs_act;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			spi_bit_q <= 5'h00;
			word_done_q <= 1'b0;
		end else if (!cs_act) begin
			spi_bit_q <= 5'h00;
			word_done_q <= 1'b0;
		end else if (sclk_rise) begin
			spi_bit_q <= spi_bit_q + 5'h01;
			word_done_q <= (spi_bit_q == `ARO_WORD_LAST);
		end else if (sclk_fall) begin
			word_done_q <= 1'b0;
		end
	end

	// ready toggle wins over a read
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_ch_q <= 3'h0;
		end else if (conv_q) begin
			rd_ch_q <= 3'h0;
		end else if (sclk_rise & (spi_bit_q == `ARO_WORD_LAST) & (rd_ch_q != `ARO_LAST_CH)) begin
			rd_ch_q <= rd_ch_q + 3'h1;
		end
	end
	assign READ_CHANNEL = rd_ch_q;

	// word loaded at select and after each full word
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			spi_sr_q <= '0;
		end else if ((cs_act & ~cs_q) | (sclk_fall & word_done_q)) begin
			spi_sr_q <= frame_q[rd_ch_q];
		end else if (sclk_fall) begin
			spi_sr_q <= {spi_sr_q[WORD_W-2:0], 1'b0};
		end
	end
	assign SPI_SDO = spi_sr_q[WORD_W-1];
	assign SPI_SDO_OE_N = ~cs_act;
endmodule // aro_port

// ---- aro_port_properties.sv ----
// concurrent checks on the ports of the result output port
`timescale 1ns/100ps
module aro_port_chk (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// configuration
	input wire logic REG_CONTROL,
	input wire logic [1:0] FORMAT_FIELD,
	input wire logic [2:0] BIT_CLOCK_DIVIDER_CODE,
	input wire logic [1:0] DRIVE_FIELD,
	input wire logic SPI_READ_EN,
	input wire logic SPI_CS_N,
	// outputs
	input wire logic RESULT_BIT_CLOCK,
	input wire logic [3:0] RESULT_LINES_OE_N,
	input wire logic [1:0] LINE_DRIVE_STRENGTH,
	input wire logic SPI_SDO_OE_N,
	input wire logic RESULT_READY_STROBE_N,
	input wire logic [2:0] READ_CHANNEL
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	a_drive_follow: assert property (
		REG_CONTROL |=> LINE_DRIVE_STRENGTH == $past(DRIVE_FIELD))
		else $error("drive strength not taken from field");
	a_chan_restart: assert property (
		$changed(RESULT_READY_STROBE_N) |-> READ_CHANNEL == 3'h0)
		else $error("channel counter not cleared by strobe");
	a_chan_step: assert property (
		$changed(READ_CHANNEL) |->
		READ_CHANNEL == 3'h0 || READ_CHANNEL == 3'($past(READ_CHANNEL) + 3'h1))
		else $error("channel counter jumped");
	a_chan_hold: assert property (
		$past(READ_CHANNEL) == 3'h7 && $stable(RESULT_READY_STROBE_N) |-> READ_CHANNEL == 3'h7)
		else $error("channel counter left last channel");
	a_sdo_enable: assert property (
		SPI_SDO_OE_N == !(!SPI_CS_N && SPI_READ_EN))
		else $error("readback output enable wrong");
	// conversion may restart the phase, so a cut high phase is allowed
	a_half_period: assert property (
		REG_CONTROL && BIT_CLOCK_DIVIDER_CODE == 3'h1 && $stable(BIT_CLOCK_DIVIDER_CODE)
		&& $rose(RESULT_BIT_CLOCK) |=>
		(RESULT_BIT_CLOCK || $changed(RESULT_READY_STROBE_N)) ##1 !RESULT_BIT_CLOCK)
		else $error("bit clock half period wrong");
	a_dual_lines: assert property (
		$changed(RESULT_READY_STROBE_N) && REG_CONTROL && FORMAT_FIELD == 2'h1 |->
		##[0:1] RESULT_LINES_OE_N == 4'hC)
		else $error("dual format line enables wrong");
	a_fmt_reserved: assert property (
		$changed(RESULT_READY_STROBE_N) && REG_CONTROL && FORMAT_FIELD == 2'h3 |->
		##[0:1] $stable(RESULT_LINES_OE_N))
		else $error("reserved format changed line enables");
endmodule // aro_port_chk
bind aro_port aro_port_chk u_chk (.*);

// ---- aro_upstream.sv ----
// upstream chained converter feeding the chain inputs
`timescale 1ns/100ps
module aro_upstream #(
	parameter logic [31:0] WORD = 32'hF0F05A3C
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// bit clock and frame mark of the device
	input wire logic RESULT_BIT_CLOCK,
	input wire logic RESULT_READY_STROBE_N,
	// chain lines toward the device
	output logic [3:0] CHAIN_O
);
	logic [31:0] a_q;
	logic [31:0] b_q;
	logic clk_q;
	logic rdy_q;
	// frame start shared with the device
	// shift after falling edge, zeros after own bits
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			a_q <= 32'h0;
			b_q <= 32'h0;
			clk_q <= 1'b0;
			rdy_q <= 1'b1;
		end else begin
			clk_q <= RESULT_BIT_CLOCK;
			rdy_q <= RESULT_READY_STROBE_N;
			if (rdy_q != RESULT_READY_STROBE_N) begin
				a_q <= WORD;
				b_q <= ~WORD;
			end else if (clk_q && !RESULT_BIT_CLOCK) begin
				a_q <= {a_q[30:0], 1'b0};
				b_q <= {b_q[30:0], 1'b0};
			end
		end
	end
	assign CHAIN_O = {b_q[31], a_q[31], 2'h0};
endmodule // aro_upstream

// ---- tb_aro_port.sv ----
// self-checking bench for the result output port
`timescale 1ns/100ps
module tb_aro_port;
	localparam logic [31:0] UPW = 32'hF0F05A3C;
	logic mclk = 1'b0, rst_n = 1'b0, s_valid = 1'b0, hold = 1'b0, reg_ctl = 1'b1;
	logic daisy = 1'b0, sclk = 1'b0, cs_n = 1'b1;
	logic [31:0] s_data = 32'h0;
	logic [1:0] fmt = 2'h2, drv = 2'h0, strength;
	logic [2:0] code = 3'h1, rch, psel = 3'h0;
	logic s_ready, bclk, sdo, sdo_oe_n, rdy_n, ovr;
	logic [3:0] lines, oe_n, up, wire_lvl;
	logic [263:0] cap0, cap1;
	int error_cnt = 0, checks_done = 0;
	always #10 mclk = ~mclk;
	// wire level from whoever drives each line
	assign wire_lvl = (~oe_n & lines) | (oe_n & up);
	aro_port u_dut (.MCLK(mclk), .RST_N(rst_n), .SAMPLE_VALID(s_valid), .SAMPLE_DATA(s_data),
		.SAMPLE_READY(s_ready), .HOLD_RESULTS(hold), .REG_CONTROL(reg_ctl), .FORMAT_PIN_0(1'b0),
		.FORMAT_PIN_1(1'b0), .FORMAT_FIELD(fmt), .RESULT_BIT_CLOCK_SELECT(psel),
		.BIT_CLOCK_DIVIDER_CODE(code), .DRIVE_FIELD(drv), .DAISY_EN(daisy), .SPI_READ_EN(1'b1),
		.RESULT_BIT_CLOCK(bclk), .RESULT_LINES_O(lines), .RESULT_LINES_OE_N(oe_n),
		.RESULT_LINES_I(wire_lvl), .LINE_DRIVE_STRENGTH(strength), .SPI_SCLK(sclk),
		.SPI_CS_N(cs_n), .SPI_SDO(sdo), .SPI_SDO_OE_N(sdo_oe_n), .RESULT_READY_STROBE_N(rdy_n),
		.READ_CHANNEL(rch), .OVERRUN(ovr));
	aro_upstream #(.WORD(UPW)) u_up (.MCLK(mclk), .RST_N(rst_n), .RESULT_BIT_CLOCK(bclk),
		.RESULT_READY_STROBE_N(rdy_n), .CHAIN_O(up));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] word(input int c, input logic [7:0] b);
		return {b, 8'hC3, 13'h0, 3'(c)};
	endfunction
	task automatic push(input logic [7:0] b);
		for (int c = 0; c < 8; c++) begin
			s_valid <= 1'b1;
			s_data <= word(c, b);
			@(posedge mclk);
			while (!s_ready) @(posedge mclk);
		end
		s_valid <= 1'b0;
	endtask
	task automatic wait_conv(input logic r);
		for (int i = 0; i < 400 && rdy_n === r; i++) @(posedge mclk);
		chk("ready strobe", 32'(!r), 32'(rdy_n));
	endtask
	// host samples just before its falling edge, where the bit is settled
	task automatic spi_read(output logic [31:0] w);
		cs_n <= 1'b0;
		repeat (2) @(posedge mclk);
		for (int i = 31; i >= 0; i--) begin
			sclk <= 1'b1;
			repeat (2) @(posedge mclk);
			w[i] = sdo;
			sclk <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		cs_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask
	task automatic capture(input int n);
		logic p;
		p = bclk;
		while (n > 0) begin
			@(posedge mclk);
			#1;
			if (bclk && !p) begin
				n--;
				cap0[n] = lines[0];
				cap1[n] = lines[1];
			end
			p = bclk;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		logic [31:0] w;
		logic r;
		time t0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int d = 0; d < 4; d++) begin
			drv <= 2'(d);
			repeat (2) @(posedge mclk);
			chk("drive strength", 32'(d), 32'(strength));
		end
		reg_ctl <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("pin mode drive", 32'h0, 32'(strength));
		reg_ctl <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			code <= 3'(k);
			repeat (2) @(posedge bclk);
			t0 = $time;
			@(posedge bclk);
			chk("bit clock period", 32'(40 << k), 32'($time - t0));
		end
		// fast ratio, first frame drains before next push
		code <= 3'h1;
		hold <= 1'b1;
		push(8'h11);
		@(posedge mclk);
		chk("full fifo ready", 32'h0, 32'(s_ready));
		r = rdy_n;
		hold <= 1'b0;
		wait_conv(r);
		capture(264);
		for (int c = 0; c < 8; c++)
			chk("line 0 word", word(c, 8'h11), cap0[263 - 32 * c -: 32]);
		chk("zero fill", 32'h0, 32'(cap0[7:0]));
		chk("empty fifo ready", 32'h1, 32'(s_ready));
		for (int c = 0; c < 10; c++) begin
			spi_read(w);
			chk("spi word", word(c > 7 ? 7 : c, 8'h11), w);
		end
		chk("read channel", 32'h7, 32'(rch));
		r = rdy_n;
		push(8'h22);
		wait_conv(r);
		chk("overrun after full frame", 32'h0, 32'(ovr));
		spi_read(w);
		chk("spi after strobe", word(0, 8'h22), w);
		chk("read channel", 32'h1, 32'(rch));
		// slower bit clock leaves the upstream model room to load
		fmt <= 2'h1;
		daisy <= 1'b1;
		// chain ratio lets both devices finish
		code <= 3'h2;
		r = rdy_n;
		push(8'h33);
		wait_conv(r);
		chk("overrun on cut frame", 32'h1, 32'(ovr));
		capture(160);
		for (int c = 0; c < 4; c++) begin
			chk("line 0 word", word(c, 8'h33), cap0[159 - 32 * c -: 32]);
			chk("line 1 word", word(c + 4, 8'h33), cap1[159 - 32 * c -: 32]);
		end
		chk("chained line 2", UPW, cap0[31:0]);
		chk("chained line 3", ~UPW, cap1[31:0]);
		fmt <= 2'h3;
		r = rdy_n;
		push(8'h44);
		wait_conv(r);
		@(posedge mclk);
		chk("reserved format enables", 32'hC, 32'(oe_n));
		reg_ctl <= 1'b0;
		psel <= 3'h3;
		r = rdy_n;
		push(8'h55);
		wait_conv(r);
		capture(72);
		for (int c = 0; c < 2; c++) begin
			chk("quad line 0", word(c, 8'h55), cap0[71 - 32 * c -: 32]);
			chk("quad line 1", word(c + 2, 8'h55), cap1[71 - 32 * c -: 32]);
		end
		chk("quad zero fill", 32'h0, 32'(cap0[7:0]));
		chk("quad enables", 32'h0, 32'(oe_n));
		@(posedge bclk);
		t0 = $time;
		@(posedge bclk);
		chk("pin mode period", 32'(40 << 3), 32'($time - t0));
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge mclk);
		error_cnt++;
		wrap_up();
	end
endmodule // tb_aro_port
